// ===== sideband_pkg.sv
// constants shared by the processor sideband error and interrupt logic
package sideband_pkg;
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned RESET_RELEASE_CLKS = 2;
  // idle pin levels held by the synchroniser in reset: {stop, lint1, lint0, init, ignore}
  localparam logic [4:0] SYNC_IDLE = 5'h13;
  // register indices on the plain register port (word addresses)
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h1;
  localparam logic [3:0] OFS_MASK = 4'h2;
  localparam logic [3:0] OFS_PINS = 4'h3;
  // control register fields
  localparam int unsigned CTRL_NE_BIT = 0;
  localparam int unsigned CTRL_LIC_EN_BIT = 1;
  localparam int unsigned CTRL_HALT_TO_NMI_BIT = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0002;
  // status / mask fields
  localparam int unsigned EV_FP_FAULT = 0;
  localparam int unsigned EV_BREAK = 1;
  localparam int unsigned EV_INTERNAL = 2;
  localparam int unsigned EV_SOFT_INIT = 3;
  localparam int unsigned EV_FP_EXC = 4;
  localparam int unsigned EV_BITS = 5;
  localparam logic [4:0] MASK_RESET = 5'h00;
endpackage

// ===== cpu_error_interrupt_sideband.sv
// sideband error, soft-init and local interrupt pin logic of the processor
module cpu_error_interrupt_sideband (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic stop_clock_request_n,
  input wire logic fp_fault_event,
  input wire logic fp_fault_masked,
  input wire logic break_event,
  input wire logic break_serviced,
  input wire logic fp_noncontrol_issue,
  input wire logic internal_error_event,
  input wire logic ignore_numeric_fault_in_n,
  input wire logic soft_init_n,
  input wire logic [1:0] local_irq_pins,
  input wire logic snoop_hit_in_n,
  input wire logic snoop_modified_flag_in_n,
  input wire logic snoop_busy,
  output logic fp_fault_break_pending_out_n,
  output logic internal_fault_out_n,
  output logic snoop_hit_out_oe_n,
  output logic snoop_modified_flag_out_oe_n,
  output logic snoop_stall_seen,
  output logic halt_transaction,
  output logic fp_exception,
  output logic integer_reset,
  output logic soft_init_active,
  output logic [1:0] local_irq_lines,
  output logic maskable_irq_request,
  output logic nonmaskable_irq_request,
  output logic irq
);
  // async inputs, packed for one synchroniser generate
  logic [4:0] async_in;
  logic [4:0] sync_q1;
  logic [4:0] sync_q2;
  assign async_in = {stop_clock_request_n, local_irq_pins, soft_init_n, ignore_numeric_fault_in_n};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          // reset to the idle pin level so no false assertion follows reset
          sync_q1[gi] <= sideband_pkg::SYNC_IDLE[gi];
          sync_q2[gi] <= sideband_pkg::SYNC_IDLE[gi];
        end else begin
          sync_q1[gi] <= async_in[gi];
          sync_q2[gi] <= sync_q1[gi];
        end
      end
    end
  endgenerate

  logic ignore_numeric_act;
  logic init_act;
  logic [1:0] lint_sync;
  logic stop_clk_act;
  assign ignore_numeric_act = !sync_q2[0];
  assign init_act = !sync_q2[1];
  assign lint_sync = sync_q2[3:2];
  assign stop_clk_act = !sync_q2[4];

  logic [31:0] ctrl;
  logic [sideband_pkg::EV_BITS-1:0] status;
  logic [sideband_pkg::EV_BITS-1:0] mask;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;
  assign wr_ctrl = reg_wr && reg_addr == sideband_pkg::OFS_CTRL;
  assign wr_status = reg_wr && reg_addr == sideband_pkg::OFS_STATUS;
  assign wr_mask = reg_wr && reg_addr == sideband_pkg::OFS_MASK;

  logic native_ne;
  logic lic_en;
  assign native_ne = ctrl[sideband_pkg::CTRL_NE_BIT];
  assign lic_en = ctrl[sideband_pkg::CTRL_LIC_EN_BIT];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= sideband_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= {29'h0000_0000, reg_wdata[2:0]};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask <= sideband_pkg::MASK_RESET;
    end else if (wr_mask) begin
      mask <= reg_wdata[sideband_pkg::EV_BITS-1:0];
    end
  end

  // floating-point fault is pending until the registered fp_exception clears it
  logic fp_pending;
  logic break_pending;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fp_pending <= 1'b0;
    end else if (fp_fault_event && !fp_fault_masked) begin
      fp_pending <= 1'b1;
    end else if (fp_exception) begin
      fp_pending <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      break_pending <= 1'b0;
    end else if (break_event) begin
      break_pending <= 1'b1;
    end else if (break_serviced || !stop_clk_act) begin
      break_pending <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fp_fault_break_pending_out_n <= 1'b1;
    end else if (stop_clk_act) begin
      fp_fault_break_pending_out_n <= !break_pending;
    end else begin
      fp_fault_break_pending_out_n <= !fp_pending;
    end
  end

  // numeric exception on a noncontrol instruction
  logic next_fp_exception;
  always_comb begin
    next_fp_exception = 1'b0;
    if (fp_noncontrol_issue && fp_pending) begin
      if (native_ne) begin
        next_fp_exception = 1'b1;
      end else if (!ignore_numeric_act) begin
        next_fp_exception = 1'b1;
      end
    end
  end
  // with ignore asserted and native bit clear, no exception and pending stays
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fp_exception <= 1'b0;
    end else begin
      fp_exception <= next_fp_exception;
    end
  end

  // internal fault: sticky until hard reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      internal_fault_out_n <= 1'b1;
    end else if (internal_error_event) begin
      internal_fault_out_n <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      halt_transaction <= 1'b0;
    end else begin
      halt_transaction <= internal_error_event && internal_fault_out_n;
    end
  end

  // soft init: integer reset pulse at the asserting edge, snoops unaffected
  logic init_prev;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_prev <= 1'b0;
      integer_reset <= 1'b0;
      soft_init_active <= 1'b0;
    end else begin
      init_prev <= init_act;
      integer_reset <= init_act && !init_prev;
      soft_init_active <= init_act;
    end
  end

  // snoop stall drive; snoop engine keeps running during soft init
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      snoop_hit_out_oe_n <= 1'b1;
      snoop_modified_flag_out_oe_n <= 1'b1;
    end else begin
      snoop_hit_out_oe_n <= !snoop_busy;
      snoop_modified_flag_out_oe_n <= !snoop_busy;
    end
  end

  // stall seen from another agent: both lines low together (sampled twice)
  logic [1:0] snp_q1;
  logic [1:0] snp_q2;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      snp_q1 <= 2'h3;
      snp_q2 <= 2'h3;
      snoop_stall_seen <= 1'b0;
    end else begin
      snp_q1 <= {snoop_hit_in_n, snoop_modified_flag_in_n};
      snp_q2 <= snp_q1;
      snoop_stall_seen <= snp_q2 == 2'h0;
    end
  end

  // local interrupt pin routing
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      local_irq_lines <= 2'h0;
      maskable_irq_request <= 1'b0;
      nonmaskable_irq_request <= 1'b0;
    end else if (lic_en) begin
      local_irq_lines <= lint_sync;
      maskable_irq_request <= 1'b0;
      nonmaskable_irq_request <= 1'b0;
    end else begin
      local_irq_lines <= 2'h0;
      maskable_irq_request <= lint_sync[0];
      nonmaskable_irq_request <= lint_sync[1];
    end
  end

  // sticky status, set wins over write-one clear
  logic [sideband_pkg::EV_BITS-1:0] ev_now;
  assign ev_now = {fp_exception, integer_reset, halt_transaction,
    break_event && stop_clk_act, fp_fault_event && !fp_fault_masked};
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
    end else begin
      status <= (status & ~(wr_status ? reg_wdata[sideband_pkg::EV_BITS-1:0] : 5'h00)) | ev_now;
    end
  end

  assign irq = |(status & mask);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        sideband_pkg::OFS_CTRL: reg_rdata <= ctrl;
        sideband_pkg::OFS_STATUS: reg_rdata <= {27'h000_0000, status};
        sideband_pkg::OFS_MASK: reg_rdata <= {27'h000_0000, mask};
        sideband_pkg::OFS_PINS: reg_rdata <= {26'h000_0000, lint_sync, init_act, ignore_numeric_act,
          !internal_fault_out_n, stop_clk_act};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  property p_fault_sticky;
    @(posedge sys_clk) disable iff (!rst_n)
      !internal_fault_out_n |=> !internal_fault_out_n;
  endproperty
  a_fault_sticky: assert property (p_fault_sticky) else $error("internal fault released");

  property p_fault_set;
    @(posedge sys_clk) disable iff (!rst_n)
      internal_error_event |=> !internal_fault_out_n;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("internal fault not raised");

  property p_halt;
    @(posedge sys_clk) disable iff (!rst_n)
      $fell(internal_fault_out_n) |-> halt_transaction;
  endproperty
  a_halt: assert property (p_halt) else $error("no halt with internal fault");

  property p_ferr;
    @(posedge sys_clk) disable iff (!rst_n)
      (!stop_clk_act && fp_pending) |=> (stop_clk_act || !fp_fault_break_pending_out_n || !$past(fp_pending));
  endproperty
  a_ferr: assert property (p_ferr) else $error("fp fault not shown");

  property p_pbe;
    @(posedge sys_clk) disable iff (!rst_n)
      (stop_clk_act && break_pending) |=> (!stop_clk_act || !fp_fault_break_pending_out_n);
  endproperty
  a_pbe: assert property (p_pbe) else $error("break not shown");

  property p_ne;
    @(posedge sys_clk) disable iff (!rst_n)
      (fp_noncontrol_issue && fp_pending && native_ne) |=> fp_exception;
  endproperty
  a_ne: assert property (p_ne) else $error("native bit ignored");

  property p_ignore;
    @(posedge sys_clk) disable iff (!rst_n)
      (ignore_numeric_act && !native_ne) |=> !fp_exception;
  endproperty
  a_ignore: assert property (p_ignore) else $error("exception while ignored");

  property p_exc;
    @(posedge sys_clk) disable iff (!rst_n)
      (fp_noncontrol_issue && fp_pending && !ignore_numeric_act) |=> fp_exception;
  endproperty
  a_exc: assert property (p_exc) else $error("exception missing");

  property p_maskable_irq_request;
    @(posedge sys_clk) disable iff (!rst_n)
      !lic_en |=> (maskable_irq_request == $past(lint_sync[0]) && nonmaskable_irq_request == $past(lint_sync[1]));
  endproperty
  a_maskable_irq_request: assert property (p_maskable_irq_request) else $error("fallback routing wrong");

  property p_stall;
    @(posedge sys_clk) disable iff (!rst_n)
      snoop_busy |=> (!snoop_hit_out_oe_n && !snoop_modified_flag_out_oe_n);
  endproperty
  a_stall: assert property (p_stall) else $error("stall lines not together");

endmodule

// ===== chipset_model.sv
// far-side chipset model: pulled-up snoop wires and stall requests
module chipset_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic stall_req,
  input wire logic hit_oe_n,
  input wire logic snoop_modified_flag_oe_n,
  output logic hit_n,
  output logic snoop_modified_flag_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drive;
  // both lines are pulled together to request a stall
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      drive <= 1'b0;
    end else begin
      drive <= stall_req;
    end
  end
  // open-drain wires pulled up, low while any party drives
  assign hit_n = hit_oe_n & !drive;
  assign snoop_modified_flag_n = snoop_modified_flag_oe_n & !drive;
endmodule

// ===== cpu_error_interrupt_sideband_bench.sv
// self-checking bench of the sideband error and interrupt logic
module cpu_error_interrupt_sideband_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] a = 4'h0;
  logic [31:0] wd = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdat;
  logic stop_n = 1'b1, msk = 1'b0, ign_n = 1'b1, init_n = 1'b1, busy = 1'b0, stall = 1'b0;
  logic [1:0] lint = 2'b00;
  logic [4:0] ev = 5'h00;
  logic hit_n, snoop_modified_flag_n, fo_n, if_n, hoe_n, hmoe_n, seen_st, halt, fpx, ireset, init_act, mi, nmi, irq;
  logic [1:0] lines;
  logic [2:0] seen = 3'h0;
  logic clr = 1'b0;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  always #2 sys_clk = ~sys_clk;
  cpu_error_interrupt_sideband i_cpu_error_interrupt_sideband (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_addr(a), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat),
    .stop_clock_request_n(stop_n), .fp_fault_event(ev[0]), .fp_fault_masked(msk),
    .break_event(ev[1]), .break_serviced(ev[2]), .fp_noncontrol_issue(ev[3]),
    .internal_error_event(ev[4]), .ignore_numeric_fault_in_n(ign_n), .soft_init_n(init_n),
    .local_irq_pins(lint), .snoop_hit_in_n(hit_n), .snoop_modified_flag_in_n(snoop_modified_flag_n),
    .snoop_busy(busy), .fp_fault_break_pending_out_n(fo_n), .internal_fault_out_n(if_n),
    .snoop_hit_out_oe_n(hoe_n), .snoop_modified_flag_out_oe_n(hmoe_n),
    .snoop_stall_seen(seen_st), .halt_transaction(halt), .fp_exception(fpx),
    .integer_reset(ireset), .soft_init_active(init_act), .local_irq_lines(lines),
    .maskable_irq_request(mi), .nonmaskable_irq_request(nmi), .irq(irq));
  chipset_model i_chipset_model (.sys_clk(sys_clk), .rst_n(rst_n), .stall_req(stall),
    .hit_oe_n(hoe_n), .snoop_modified_flag_oe_n(hmoe_n), .hit_n(hit_n), .snoop_modified_flag_n(snoop_modified_flag_n));
  // pulses are caught here so a check may look later
  always @(posedge sys_clk) begin
    seen <= clr ? 3'h0 : seen | {ireset, fpx, halt};
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      wrap_up();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    step(1);
    ev[i] <= 1'b0;
  endtask
  task automatic wreg(input logic [3:0] ad, input logic [31:0] d);
    a <= ad;
    wd <= d;
    wr <= 1'b1;
    step(1);
    wr <= 1'b0;
    step(1);
  endtask
  task automatic rreg(input logic [3:0] ad, output logic [31:0] d);
    a <= ad;
    rd <= 1'b1;
    step(1);
    rd <= 1'b0;
    #1 d = rdat;
    step(1);
  endtask
  task automatic t_reset;
    logic [31:0] d;
    rreg(4'h0, d);
    chk("ctrl", d, 32'h0000_0002);
    rreg(4'h2, d);
    chk("mask", d, 32'h0000_0000);
    lint <= 2'b01;
    step(4);
    chk("lines", 32'(lines), 32'h0000_0001);
    $display("test reset done");
  endtask
  task automatic t_break;
    stop_n <= 1'b0;
    step(4);
    pulse(1);
    step(3);
    chk("pbe", 32'(fo_n), 32'h0000_0000);
    pulse(2);
    step(3);
    chk("pbe clr", 32'(fo_n), 32'h0000_0001);
    stop_n <= 1'b1;
    step(4);
    $display("test break done");
  endtask
  task automatic t_fp;
    msk <= 1'b1;
    pulse(0);
    msk <= 1'b0;
    step(3);
    chk("fp masked", 32'(fo_n), 32'h0000_0001);
    pulse(0);
    step(3);
    chk("fp", 32'(fo_n), 32'h0000_0000);
    ign_n <= 1'b0;
    step(4);
    clr <= 1'b1;
    pulse(3);
    clr <= 1'b0;
    step(2);
    chk("ignored", 32'(seen[1]), 32'h0000_0000);
    wreg(4'h0, 32'h0000_0003);
    pulse(3);
    step(2);
    chk("ne set", 32'(seen[1]), 32'h0000_0001);
    wreg(4'h0, 32'h0000_0002);
    ign_n <= 1'b1;
    pulse(0);
    step(4);
    clr <= 1'b1;
    pulse(3);
    clr <= 1'b0;
    step(2);
    chk("fp exc", 32'(seen[1]), 32'h0000_0001);
    $display("test numeric done");
  endtask
  task automatic t_lint;
    wreg(4'h0, 32'h0000_0000);
    lint <= 2'b10;
    step(4);
    chk("nmi", {30'h0, nmi, mi}, 32'h0000_0002);
    lint <= 2'b01;
    step(4);
    chk("maskable_irq_request", {30'h0, nmi, mi}, 32'h0000_0001);
    stall <= 1'b1;
    step(5);
    chk("stall seen", 32'(seen_st), 32'h0000_0001);
    stall <= 1'b0;
    $display("test lint done");
  endtask
  task automatic t_internal_fault_out;
    logic [31:0] d;
    wreg(4'h1, 32'h0000_001F);
    wreg(4'h2, 32'h0000_0004);
    clr <= 1'b1;
    pulse(4);
    clr <= 1'b0;
    step(2);
    chk("internal_fault_out", {29'h0, seen[0], if_n, irq}, 32'h0000_0005);
    rreg(4'h1, d);
    chk("status", d & 32'h0000_0004, 32'h0000_0004);
    wreg(4'h1, 32'h0000_0004);
    step(10);
    chk("irq clr", {30'h0, if_n, irq}, 32'h0000_0000);
    rreg(4'hF, d);
    chk("unmapped", d, 32'h0000_0000);
    rreg(4'h3, d);
    chk("pins", d, 32'h0000_0012);
    init_n <= 1'b0;
    step(5);
    chk("init", {30'h0, seen[2], init_act}, 32'h0000_0003);
    busy <= 1'b1;
    step(2);
    chk("snoop", {30'h0, hoe_n, hmoe_n}, 32'h0000_0000);
    init_n <= 1'b1;
    rst_n <= 1'b0;
    step(2);
    chk("released", {29'h0, hoe_n, hmoe_n, if_n}, 32'h0000_0007);
    rst_n <= 1'b1;
    busy <= 1'b0;
    $display("test fault done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    step(16);
    rst_n <= 1'b1;
    step(1);
    t_reset();
    t_break();
    t_fp();
    t_lint();
    t_internal_fault_out();
    step(2);
    wrap_up();
  end
endmodule
